// >>> ras_pkg.sv
// package: constants and types for the return-address stack
package ras_pkg;

  localparam int unsigned PTR_W       = 4;
  localparam int unsigned ADDR_W      = 13;
  localparam int unsigned SLOT_W      = 16;
  localparam int unsigned SLOT_COUNT  = 9;
  localparam int unsigned REG_ADDR_W  = 7;

  localparam logic [REG_ADDR_W-1:0] STACK_POINTER_OFFSET = 7'h01;
  localparam logic [PTR_W-1:0]      STACK_POINTER_RESET  = 4'h9;
  localparam logic [PTR_W-1:0]      LAST_SLOT            = 4'h8;
  localparam logic [PTR_W-1:0]      PTR_ONE              = 4'h1;

  // operation requested by the instruction sequencer
  typedef enum logic [2:0]
  {
    OP_NONE      = 3'b000,
    OP_CALL      = 3'b001,
    OP_RETURN    = 3'b010,
    OP_TABLE     = 3'b011,
    OP_INTERRUPT = 3'b100,
    OP_PUSH      = 3'b101,
    OP_POP       = 3'b110
  } stack_op_t;

  typedef struct packed
  {
    logic                  valid;
    logic                  write;
    logic [REG_ADDR_W-1:0] addr;
    logic [PTR_W-1:0]      wdata;
  } reg_req_t;

  typedef struct packed
  {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } addr_load_t;

endpackage

// >>> ras_slot_store.sv
// slot storage of the return-address stack: nine slots, upper bits zero
`timescale 1ns/100ps
`default_nettype none
module ras_slot_store
(
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_ce,
  input  wire logic                       i_we,
  input  wire logic [ras_pkg::PTR_W-1:0]  i_waddr,
  input  wire logic [ras_pkg::ADDR_W-1:0] i_wdata,
  input  wire logic [ras_pkg::PTR_W-1:0]  i_raddr,
  output logic      [ras_pkg::SLOT_W-1:0] o_rdata
);
  import ras_pkg::*;

  logic [ADDR_W-1:0] slot_q [SLOT_COUNT];

  // ************************************************************
  // slot registers
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < SLOT_COUNT; g++)
    begin : g_slot
      always_ff @(posedge i_core_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          slot_q[g] <= '0;
        else if (i_ce && i_we && i_waddr == PTR_W'(g))
          slot_q[g] <= i_wdata;
      end
    end
  endgenerate

  // ************************************************************
  // read port
  // ************************************************************
  always_comb
  begin
    // slots 9..15 have no storage; they read zero
    if (i_raddr <= LAST_SLOT)
      o_rdata = {3'h0, slot_q[i_raddr]};
    else
      o_rdata = '0;
  end
endmodule
`default_nettype wire

// >>> return_address_stack.sv
// return-address stack: pointer, sequencer operations and register port
// What this block does
// - four-bit stack pointer selects sixteen slot positions
// - pointer read/write at register address 01H
// - every reset loads pointer with 1001b; clock-stop and chip-enable resets only while i_ce is high
// - call decrements pointer, then saves return
// - return loads counter from slot, then increments
// - table reference starts with decrement and save
// - table reads word, restores counter, increments
// - interrupt decrements pointer, then saves return
// - interrupt return restores counter, then increments
// - push decrements, then stores address pointer
// - pop loads address pointer, then increments
// - slots nine to fifteen read zero
// - nine slots, upper three bits zero
`timescale 1ns/100ps
`default_nettype none
module return_address_stack
(
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_ce,
  input  wire logic                       i_clock_stop_reset,
  input  wire logic                       i_chip_enable_reset,
  input  wire ras_pkg::stack_op_t         i_op,
  input  wire logic [ras_pkg::ADDR_W-1:0] i_next_pc,
  input  wire logic [ras_pkg::ADDR_W-1:0] i_address_pointer_register,
  input  wire logic [ras_pkg::SLOT_W-1:0] i_table_word,
  input  wire ras_pkg::reg_req_t          i_reg_req,
  output logic      [ras_pkg::PTR_W-1:0]  o_reg_rdata,
  output logic      [ras_pkg::ADDR_W-1:0] o_table_addr,
  output logic                            o_busy,
  output ras_pkg::addr_load_t             o_program_counter_load,
  output ras_pkg::addr_load_t             o_address_pointer_load,
  output logic                            o_table_data_buffer_load,
  output logic      [ras_pkg::SLOT_W-1:0] o_table_data_buffer,
  output logic      [ras_pkg::PTR_W-1:0]  o_stack_pointer
);
  import ras_pkg::*;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_RESTORE = 2'b10
  } table_state_t;

  logic [1:0]        rst_sync_q;
  logic              rst_n_int;
  logic [PTR_W-1:0]  stack_pointer_q;
  logic [PTR_W-1:0]  stack_pointer_d;
  logic [SLOT_W-1:0] slot_rdata;
  logic              slot_we;
  logic [ADDR_W-1:0] slot_wdata;
  table_state_t      table_state_q;
  table_state_t      table_state_d;
  logic [ADDR_W-1:0] table_addr_q;
  logic              pc_load_valid_q;
  logic [ADDR_W-1:0] pc_load_addr_q;
  logic              apr_load_valid_q;
  logic [ADDR_W-1:0] apr_load_addr_q;
  logic              op_idle;
  logic              table_start;
  logic              sp_step_down;
  logic              sp_step_up;
  logic              sp_write;
  logic              sync_reset;
  logic              pc_restore;
  logic              apr_restore;
  logic              reg_read;
  logic [PTR_W-1:0]  sp_dec;
  logic [PTR_W-1:0]  sp_inc;
  logic              tdb_load_q;
  logic [SLOT_W-1:0] tdb_q;
  logic [PTR_W-1:0]  reg_rdata_q;

  // decrementing ops write the slot the new pointer selects
  function automatic logic is_save_op(input stack_op_t op);
    return op == OP_CALL || op == OP_TABLE || op == OP_INTERRUPT || op == OP_PUSH;
  endfunction

  // incrementing ops read the slot the current pointer selects
  function automatic logic is_restore_op(input stack_op_t op);
    return op == OP_RETURN || op == OP_POP;
  endfunction

  // register port decode, shared by the write and read paths
  function automatic logic hits_stack_pointer(input reg_req_t req);
    return req.valid && req.addr == STACK_POINTER_OFFSET;
  endfunction

  // ************************************************************
  // reset release
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // release is synchronised so no flop leaves reset a cycle early
  assign rst_n_int = rst_sync_q[1];

  // ************************************************************
  // operation decode
  // ************************************************************
  // ops are taken only while no table reference is in flight
  assign op_idle      = (table_state_q == ST_IDLE);
  assign table_start  = op_idle && (i_op == OP_TABLE);
  assign sp_step_down = op_idle && is_save_op(i_op);
  assign sp_step_up   = (table_state_q == ST_RESTORE)
                        || (op_idle && is_restore_op(i_op));
  // a write loses against an op in the same cycle
  assign sp_write     = op_idle && i_reg_req.write && hits_stack_pointer(i_reg_req);
  assign reg_read     = i_reg_req.valid && !i_reg_req.write;
  assign sync_reset   = i_clock_stop_reset || i_chip_enable_reset;
  assign sp_dec       = stack_pointer_q - PTR_ONE;
  assign sp_inc       = stack_pointer_q + PTR_ONE;
  assign pc_restore   = (table_state_q == ST_RESTORE)
                        || (op_idle && i_op == OP_RETURN);
  assign apr_restore  = op_idle && (i_op == OP_POP);

  // ************************************************************
  // slot storage
  // ************************************************************
  assign slot_we = sp_step_down;

  // push saves the address pointer, others the next instruction address
  always_comb
  begin
    case (i_op)
      OP_PUSH:
        slot_wdata = i_address_pointer_register;
      default:
        slot_wdata = i_next_pc;
    endcase
  end

  ras_slot_store u_slots
  (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n_int),
    .i_ce       (i_ce),
    .i_we       (slot_we),
    .i_waddr    (sp_dec),
    .i_wdata    (slot_wdata),
    .i_raddr    (stack_pointer_q),
    .o_rdata    (slot_rdata)
  );

  // ************************************************************
  // table reference sequence
  // ************************************************************
  always_comb
  begin
    table_state_d = table_state_q;
    case (table_state_q)
      ST_IDLE:
        if (table_start)
          table_state_d = ST_FETCH;
      ST_FETCH:
        table_state_d = ST_RESTORE;
      ST_RESTORE:
        table_state_d = ST_IDLE;
      default:
        table_state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
      table_state_q <= ST_IDLE;
    else if (i_ce)
      table_state_q <= table_state_d;
  end

  always_ff @(posedge i_core_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
      table_addr_q <= '0;
    else if (i_ce && table_start)
      table_addr_q <= i_address_pointer_register;
  end

  always_ff @(posedge i_core_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
      tdb_load_q <= 1'b0;
    else if (i_ce)
      tdb_load_q <= (table_state_q == ST_FETCH);
  end

  // the buffer keeps the fetched word until the next table reference
  always_ff @(posedge i_core_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
      tdb_q <= '0;
    else if (i_ce && table_state_q == ST_FETCH)
      tdb_q <= i_table_word;
  end

  // ************************************************************
  // stack pointer
  // ************************************************************
  always_comb
  begin
    stack_pointer_d = stack_pointer_q;
    if (sp_step_up)
      stack_pointer_d = sp_inc;
    else if (sp_step_down)
      stack_pointer_d = sp_dec;
    else if (sp_write)
      stack_pointer_d = i_reg_req.wdata;
  end

  always_ff @(posedge i_core_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
      stack_pointer_q <= STACK_POINTER_RESET;
    else if (i_ce)
    begin
      // clock-stop and chip-enable resets win over any op or write
      if (sync_reset)
        stack_pointer_q <= STACK_POINTER_RESET;
      else
        stack_pointer_q <= stack_pointer_d;
    end
  end

  // ************************************************************
  // restore to program counter
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
      pc_load_valid_q <= 1'b0;
    else if (i_ce)
      pc_load_valid_q <= pc_restore;
  end

  // the address stands until the next restore
  always_ff @(posedge i_core_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
      pc_load_addr_q <= '0;
    else if (i_ce && pc_restore)
      pc_load_addr_q <= slot_rdata[ADDR_W-1:0];
  end

  // ************************************************************
  // restore to address pointer
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
      apr_load_valid_q <= 1'b0;
    else if (i_ce)
      apr_load_valid_q <= apr_restore;
  end

  always_ff @(posedge i_core_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
      apr_load_addr_q <= '0;
    else if (i_ce && apr_restore)
      apr_load_addr_q <= slot_rdata[ADDR_W-1:0];
  end

  // ************************************************************
  // register read port
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
      reg_rdata_q <= '0;
    else if (i_ce && reg_read)
    begin
      // other addresses read as zero
      if (hits_stack_pointer(i_reg_req))
        reg_rdata_q <= stack_pointer_q;
      else
        reg_rdata_q <= '0;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign o_reg_rdata              = reg_rdata_q;
  assign o_table_addr             = table_addr_q;
  assign o_busy                   = (table_state_q != ST_IDLE);
  assign o_program_counter_load   = '{valid: pc_load_valid_q, addr: pc_load_addr_q};
  assign o_address_pointer_load   = '{valid: apr_load_valid_q, addr: apr_load_addr_q};
  assign o_table_data_buffer_load = tdb_load_q;
  assign o_table_data_buffer      = tdb_q;
  assign o_stack_pointer          = stack_pointer_q;
endmodule
`default_nettype wire

// >>> ras_properties.sv
// assertions on the ports of the return-address stack
`timescale 1ns/100ps
`default_nettype none
module ras_properties
(
  input wire logic                i_core_clk,
  input wire logic                i_rst_n,
  input wire logic                i_ce,
  input wire logic                i_clock_stop_reset,
  input wire logic                i_chip_enable_reset,
  input wire ras_pkg::stack_op_t  i_op,
  input wire logic [12:0]         i_next_pc,
  input wire logic [12:0]         i_address_pointer_register,
  input wire ras_pkg::reg_req_t   i_reg_req,
  input wire logic [3:0]          o_reg_rdata,
  input wire logic [12:0]         o_table_addr,
  input wire logic                o_busy,
  input wire ras_pkg::addr_load_t o_program_counter_load,
  input wire ras_pkg::addr_load_t o_address_pointer_load,
  input wire logic                o_table_data_buffer_load,
  input wire logic [3:0]          o_stack_pointer
);
  import ras_pkg::*;
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  wire logic t = i_ce && !o_busy && !i_clock_stop_reset && !i_chip_enable_reset;
  wire logic rg = i_reg_req.valid && i_reg_req.addr == STACK_POINTER_OFFSET;
  // ****************
  // pointer steps
  // ****************
  sequence s_dec;
    o_stack_pointer == $past(o_stack_pointer) - 4'h1;
  endsequence
  sequence s_inc;
    o_stack_pointer == $past(o_stack_pointer) + 4'h1;
  endsequence
  sequence s_fetch;
    o_busy && o_table_addr == $past(i_address_pointer_register) ##0 s_dec;
  endsequence
  // slots above eight keep nothing, so the restore then reads zero
  sequence s_back;
    !o_busy && o_program_counter_load.valid && o_stack_pointer == $past(o_stack_pointer, 3)
      && o_program_counter_load.addr == ((($past(o_stack_pointer, 3) - 4'h1) <= 4'h8)
                                         ? $past(i_next_pc, 3) : 13'h0);
  endsequence
  property p_call; t && i_op == OP_CALL |=> s_dec; endproperty
  a_call: assert property (p_call) else $error("call");
  property p_int; t && i_op == OP_INTERRUPT |=> s_dec; endproperty
  a_int: assert property (p_int) else $error("interrupt");
  property p_push; t && i_op == OP_PUSH |=> s_dec; endproperty
  a_push: assert property (p_push) else $error("push");
  property p_ret; t && i_op == OP_RETURN |=> o_program_counter_load.valid ##0 s_inc; endproperty
  a_ret: assert property (p_ret) else $error("return");
  property p_pop; t && i_op == OP_POP |=> o_address_pointer_load.valid ##0 s_inc; endproperty
  a_pop: assert property (p_pop) else $error("pop");
  property p_hole; t && i_op == OP_POP && o_stack_pointer > 4'h8 |=> o_address_pointer_load.addr == 13'h0; endproperty
  a_hole: assert property (p_hole) else $error("empty slot");
  property p_table; t && i_op == OP_TABLE |=> s_fetch ##1 o_table_data_buffer_load ##1 s_back; endproperty
  a_table: assert property (p_table) else $error("table");
  property p_wr; t && i_op == OP_NONE && rg && i_reg_req.write |=> o_stack_pointer == $past(i_reg_req.wdata); endproperty
  a_wr: assert property (p_wr) else $error("write");
  property p_rd; i_ce && !o_busy && rg && !i_reg_req.write |=> o_reg_rdata == $past(o_stack_pointer); endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_rst; i_ce && (i_clock_stop_reset || i_chip_enable_reset) |=> o_stack_pointer == 4'h9; endproperty
  a_rst: assert property (p_rst) else $error("sync reset");
  property p_hold; !i_ce |=> $stable(o_stack_pointer); endproperty
  a_hold: assert property (p_hold) else $error("frozen");
endmodule
bind return_address_stack ras_properties i_props
(
  .i_core_clk, .i_rst_n, .i_ce, .i_clock_stop_reset, .i_chip_enable_reset, .i_op, .i_next_pc,
  .i_address_pointer_register, .i_reg_req, .o_reg_rdata, .o_table_addr, .o_busy,
  .o_program_counter_load, .o_address_pointer_load, .o_table_data_buffer_load, .o_stack_pointer
);
`default_nettype wire

// >>> ras_program_memory.sv
// program memory model answering table fetches
`timescale 1ns/100ps
`default_nettype none
module ras_program_memory
(
  input  wire logic        i_busy,
  input  wire logic [12:0] i_addr,
  output logic      [15:0] o_word
);
  // idle bus shows the inverse so a late sample cannot pass
  assign o_word = {3'h5, i_addr} ^ (i_busy ? 16'hA5A5 : 16'h5A5A);
endmodule
`default_nettype wire

// >>> return_address_stack_test.sv
// self-checking bench of the return-address stack
`timescale 1ns/100ps
`default_nettype none
module return_address_stack_test;
  import ras_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, csr = 0, cer = 0, busy, tload;
  logic [12:0] npc = '0, apr = '0, taddr, mem [16];
  logic [15:0] word, tbuf;
  logic [3:0] rdata, sp, rsp;
  stack_op_t op = OP_NONE;
  reg_req_t req = '0;
  addr_load_t pcl, arl;
  int error_cnt = 0, checks = 0, r;
  always #2 clk = ~clk;
  ras_program_memory i_mem (.i_busy(busy), .i_addr(taddr), .o_word(word));
  return_address_stack i_dut
  (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_clock_stop_reset(csr),
    .i_chip_enable_reset(cer), .i_op(op), .i_next_pc(npc), .i_address_pointer_register(apr),
    .i_table_word(word), .i_reg_req(req), .o_reg_rdata(rdata), .o_table_addr(taddr),
    .o_busy(busy), .o_program_counter_load(pcl), .o_address_pointer_load(arl),
    .o_table_data_buffer_load(tload), .o_table_data_buffer(tbuf), .o_stack_pointer(sp)
  );
  // ****************
  // helpers
  // ****************
  function automatic logic [12:0] slot(input logic [3:0] p);
    return p < 4'h9 ? mem[p] : 13'h0;
  endfunction
  task automatic chk_sp(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t pointer %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_dat(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t data %h not %h", $time, got, exp);
    end
  endtask
  task automatic do_op(input stack_op_t o);
    op = o;
    npc = 13'($urandom);
    apr = 13'($urandom);
    @(negedge clk);
    if (o == OP_RETURN || o == OP_POP)
    begin
      chk_dat(o == OP_POP ? arl : pcl, {1'b1, slot(rsp)});
      rsp++;
    end
    else
    begin
      rsp--;
      if (rsp < 4'h9) mem[rsp] = o == OP_PUSH ? apr : npc;
    end
    if (o == OP_TABLE)
    begin
      chk_dat(taddr, apr);
      @(negedge clk);
      chk_dat({tload, tbuf}, {1'b1, ({3'h5, apr} ^ 16'hA5A5)});
      @(negedge clk);
      chk_dat(pcl, {1'b1, slot(rsp)});
      rsp++;
    end
    chk_sp(sp, rsp);
  endtask
  task automatic reg_acc(input logic w);
    logic [6:0] a;
    a = $urandom % 3 == 0 ? 7'($urandom) : STACK_POINTER_OFFSET;
    op = OP_NONE;
    req = '{1'b1, w, a, 4'($urandom)};
    @(negedge clk);
    req.valid = 1'b0;
    if (!w) chk_sp(rdata, a == STACK_POINTER_OFFSET ? rsp : 4'h0);
    if (w && a == STACK_POINTER_OFFSET) rsp = req.wdata;
    chk_sp(sp, rsp);
    @(negedge clk);
  endtask
  task automatic rst();
    op = OP_NONE;
    rst_n = 1'b0;
    rsp = 4'h9;
    mem = '{default: 13'h0};
    repeat (2) @(negedge clk);
    chk_sp(sp, 4'h9);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    end_sim();
  end
  initial
  begin
    void'($urandom(90));
    rst();
    $display("test reset done");
    repeat (11) do_op(OP_CALL);
    repeat (11) do_op(OP_RETURN);
    $display("test overflow done");
    op = OP_CALL;
    ce = 1'b0;
    @(negedge clk);
    ce = 1'b1;
    chk_sp(sp, rsp);
    $display("test enable done");
    repeat (400)
    begin
      r = $urandom % 8;
      if (r < 6) do_op(stack_op_t'(3'(r + 1)));
      else if (r == 6 || $urandom % 3 != 0) reg_acc(1'($urandom));
      else
      begin
        op = OP_NONE;
        csr = 1'($urandom);
        cer = !csr;
        @(negedge clk);
        csr = 1'b0;
        cer = 1'b0;
        rsp = 4'h9;
        chk_sp(sp, rsp);
      end
    end
    $display("test random done");
    rst();
    $display("test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
